// ==== hdl/utg_ahb_slave.sv ====
// Purpose: AHB-Lite slave front end for the transmit gate and multidrop registers.
// Assumes: Single word transfers only; the response is always OKAY.
// Notes:   Writes take no wait state; reads take one so the returned word is always current.
`timescale 1ns/1ps
`default_nettype none

module utg_ahb_slave
	import utg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	input  wire logic [31:0] rd_data,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic [31:0]      reg_addr,
	output logic             reg_wr,
	output logic [31:0]      reg_wdata
);

	utg_ahb_st_t s_q;
	utg_ahb_st_t s_d;
	logic        accept;

	// A transfer is taken on NONSEQ or SEQ while the bus is ready.
	assign accept = hsel && hready && htrans[1];

	// Address phase capture, write strobe and delayed read capture.
	always_comb begin
		s_d         = s_q;
		s_d.wr_pend = 1'b0;
		if (s_q.rd_pend) begin
			// The word is sampled one cycle late so a write just before it is already visible.
			s_d.rdata   = rd_data;
			s_d.rd_pend = 1'b0;
			s_d.ready   = 1'b1;
		end
		if (accept) begin
			s_d.addr    = haddr;
			s_d.wr_pend = hwrite;
			s_d.rd_pend = !hwrite;
			s_d.ready   = hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{addr: 32'h0000_0000, wr_pend: 1'b0, rd_pend: 1'b0, ready: 1'b1, rdata: 32'h0000_0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = s_q.ready;
	assign hrdata    = s_q.rdata;
	assign hresp     = 1'b0;
	assign reg_addr  = s_q.addr;
	assign reg_wr    = s_q.wr_pend;
	assign reg_wdata = hwdata;

endmodule // utg_ahb_slave

`default_nettype wire

// ==== hdl/utg_pkg.sv ====
// Purpose: Types shared by the transmit gate and multidrop block.
// Assumes: Field widths come from utg_regs.svh.
// Notes:   The bus slave and the core each keep all their state in one packed struct.
`include "utg_regs.svh"

package utg_pkg;

	// State of the bus slave.
	typedef struct packed {
		logic [31:0] addr;
		logic        wr_pend;
		logic        rd_pend;
		logic        ready;
		logic [31:0] rdata;
	} utg_ahb_st_t;

	// State of the core.
	typedef struct packed {
		logic                  tx_gate;
		logic [`UTG_MD_CTRL_W-1:0] md_ctrl;
		logic [7:0]            match;
		logic [`UTG_IRQ_W-1:0] status;
		logic [`UTG_IRQ_W-1:0] mask;
		logic                  tx_load;
		logic                  tx_busy;
		logic                  dir_active;
		logic                  rts;
		logic                  dtr;
		logic                  rx_store;
		logic [8:0]            rx_data;
		logic                  irq;
	} utg_core_st_t;

endpackage

// ==== hdl/utg_regs.svh ====
// Purpose: Register addresses, field positions and reset values of the transmit gate and multidrop block.
// Assumes: Word-aligned 32-bit registers on an AHB-Lite slave.
// Notes:   Definitions only; include by bare name.
`ifndef UTG_REGS_SVH
`define UTG_REGS_SVH

// Byte addresses of the registers.
`define UTG_TX_GATE_ADDR      32'h4000_8030
`define UTG_MD_CTRL_ADDR      32'h4000_804C
`define UTG_ADDR_MATCH_ADDR   32'h4000_8050
`define UTG_IRQ_STATUS_ADDR   32'h4000_8060
`define UTG_IRQ_MASK_ADDR     32'h4000_8064

// Transmit gate register.
`define UTG_TX_GATE_BIT       7
`define UTG_TX_GATE_RST       1'h1

// Multidrop control register fields.
`define UTG_MD_NMM_BIT        0
`define UTG_MD_RX_DISABLE_BIT      1
`define UTG_MD_AAD_BIT        2
`define UTG_MD_SEL_BIT        3
`define UTG_MD_ADIR_BIT       4
`define UTG_MD_INV_BIT        5
`define UTG_MD_CTRL_W         6
`define UTG_MD_CTRL_RST       6'h00
`define UTG_ADDR_MATCH_RST    8'h00

// Interrupt status and mask fields.
`define UTG_IRQ_ADDR_BIT      0
`define UTG_IRQ_TXDONE_BIT    1
`define UTG_IRQ_RXDROP_BIT    2
`define UTG_IRQ_W             3
`define UTG_IRQ_RST           3'h0

`endif

// ==== hdl/utg_top.sv ====
// Purpose: Transmit gating and multidrop (address filter, direction control) logic of a UART.
// Assumes: The transmit FIFO pops on tx_load; the shift register drops tx_shift_idle the cycle after.
// Notes:   Baud generation, driver delay and the FIFOs themselves live outside this block.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "utg_regs.svh"

module utg_top
	import utg_pkg::*;
#(
	parameter int MATCH_W = 8
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        tx_fifo_valid,
	input  wire logic        tx_fifo_write,
	input  wire logic        tx_shift_idle,
	output logic             tx_load,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_parity,
	output logic             rx_store,
	output logic [8:0]       rx_store_data,
	input  wire logic        modem_rts,
	input  wire logic        modem_dtr,
	output logic             rts_out,
	output logic             dtr_out,
	output logic             irq
);

	// The address comparator is written for the documented byte-wide match value.
	generate
		if (MATCH_W != 8) begin : g_bad_match_w
			$error("utg_top supports MATCH_W of 8 only");
		end
	endgenerate

	utg_core_st_t c_q;
	utg_core_st_t c_d;
	logic [31:0]  reg_addr;
	logic         reg_wr;
	logic [31:0]  reg_wdata;
	logic [31:0]  rd_data;
	logic         tx_pending;
	logic         is_addr;
	logic         addr_hit;
	logic         nmm;
	logic         aad_mode;
	logic         rx_dis;
	logic         dir_level;
	logic [`UTG_IRQ_W-1:0] events;
	logic         unused_ok;

	// Only whole words are used; the transfer size carries no extra meaning here.
	assign unused_ok = &{1'b0, hsize};

	utg_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.rd_data   (rd_data),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata)
	);

	// Read mux; reserved positions and unmapped addresses return zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		case (reg_addr)
			`UTG_TX_GATE_ADDR: begin
				rd_data[`UTG_TX_GATE_BIT] = c_q.tx_gate;
			end
			`UTG_MD_CTRL_ADDR: begin
				rd_data[`UTG_MD_CTRL_W-1:0] = c_q.md_ctrl;
			end
			`UTG_ADDR_MATCH_ADDR: begin
				rd_data[7:0] = c_q.match;
			end
			`UTG_IRQ_STATUS_ADDR: begin
				rd_data[`UTG_IRQ_W-1:0] = c_q.status;
			end
			`UTG_IRQ_MASK_ADDR: begin
				rd_data[`UTG_IRQ_W-1:0] = c_q.mask;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// Decoded mode bits.
	assign nmm      = c_q.md_ctrl[`UTG_MD_NMM_BIT];
	assign aad_mode = nmm && c_q.md_ctrl[`UTG_MD_AAD_BIT];
	assign rx_dis   = c_q.md_ctrl[`UTG_MD_RX_DISABLE_BIT];

	// In multidrop mode the ninth bit set is what marks an address character.
	assign is_addr  = nmm && rx_parity;
	assign addr_hit = (rx_byte == c_q.match);

	// Transmit data is pending while the FIFO holds data, a load is in flight, or a character shifts.
	assign tx_pending = tx_fifo_valid || c_q.tx_load || !tx_shift_idle;

	// Direction level for the selected pin; idle is high unless inverted.
	assign dir_level = c_q.dir_active ^ !c_q.md_ctrl[`UTG_MD_INV_BIT];

	// Next state of the whole core.
	always_comb begin
		c_d          = c_q;
		events       = '0;
		c_d.tx_load  = 1'b0;
		c_d.rx_store = 1'b0;

		// Software writes come first so that hardware updates below take priority over them.
		if (reg_wr) begin
			case (reg_addr)
				`UTG_TX_GATE_ADDR: begin
					c_d.tx_gate = reg_wdata[`UTG_TX_GATE_BIT];
				end
				`UTG_MD_CTRL_ADDR: begin
					c_d.md_ctrl = reg_wdata[`UTG_MD_CTRL_W-1:0];
				end
				`UTG_ADDR_MATCH_ADDR: begin
					c_d.match = reg_wdata[7:0];
				end
				`UTG_IRQ_STATUS_ADDR: begin
					c_d.status = c_q.status & ~reg_wdata[`UTG_IRQ_W-1:0];
				end
				`UTG_IRQ_MASK_ADDR: begin
					c_d.mask = reg_wdata[`UTG_IRQ_W-1:0];
				end
				default: begin
					c_d.match = c_d.match;
				end
			endcase
		end

		// One load per idle shifter; the cycle after a load is skipped so the FIFO and
		// shifter can report the pop before the next decision.
		// A cleared gate only stops the next load, never the character already shifting.
		if (c_q.tx_gate && tx_fifo_valid && tx_shift_idle && !c_q.tx_load) begin
			c_d.tx_load = 1'b1;
		end

		// Transmitter drained: report it once when pending falls.
		c_d.tx_busy = tx_pending;
		if (c_q.tx_busy && !tx_pending) begin
			events[`UTG_IRQ_TXDONE_BIT] = 1'b1;
		end

		// Direction request raised by a FIFO write and dropped once the last bit has left.
		if (tx_fifo_write) begin
			c_d.dir_active = 1'b1;
		end else if (!tx_pending) begin
			c_d.dir_active = 1'b0;
		end

		// Pin drive; with direction control off both pins follow the modem sources.
		c_d.rts = modem_rts;
		c_d.dtr = modem_dtr;
		if (c_q.md_ctrl[`UTG_MD_ADIR_BIT]) begin
			if (c_q.md_ctrl[`UTG_MD_SEL_BIT]) begin
				c_d.dtr = dir_level;
			end else begin
				c_d.rts = dir_level;
			end
		end

		// Receive filter.
		if (rx_byte_valid) begin
			c_d.rx_data = {rx_parity, rx_byte};
			if (is_addr) begin
				events[`UTG_IRQ_ADDR_BIT] = 1'b1;
			end
			if (aad_mode && is_addr) begin
				// A matching address always lands and opens the receiver; a foreign one closes it.
				if (addr_hit) begin
					c_d.rx_store                  = 1'b1;
					c_d.md_ctrl[`UTG_MD_RX_DISABLE_BIT] = 1'b0;
				end else begin
					c_d.md_ctrl[`UTG_MD_RX_DISABLE_BIT] = 1'b1;
					events[`UTG_IRQ_RXDROP_BIT]    = 1'b1;
				end
			end else if (!rx_dis) begin
				c_d.rx_store = 1'b1;
			end else if (is_addr && !aad_mode) begin
				// Normal multidrop keeps addresses so software can decide on the data that follows.
				c_d.rx_store = 1'b1;
			end else begin
				events[`UTG_IRQ_RXDROP_BIT] = 1'b1;
			end
		end

		// Sticky status; a new event wins over a clear in the same cycle.
		c_d.status = c_d.status | events;
		c_d.irq    = |(c_d.status & c_d.mask);
	end

	// State register; the gate bit comes up set so characters flow right after reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_q            <= '0;
			c_q.tx_gate    <= `UTG_TX_GATE_RST;
			c_q.md_ctrl    <= `UTG_MD_CTRL_RST;
			c_q.match      <= `UTG_ADDR_MATCH_RST;
			c_q.status     <= `UTG_IRQ_RST;
			c_q.mask       <= `UTG_IRQ_RST;
			c_q.rts        <= 1'b1;
			c_q.dtr        <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// Every output comes straight from the state register.
	assign tx_load       = c_q.tx_load;
	assign rx_store      = c_q.rx_store;
	assign rx_store_data = c_q.rx_data;
	assign rts_out       = c_q.rts;
	assign dtr_out       = c_q.dtr;
	assign irq           = c_q.irq;

endmodule // utg_top

`default_nettype wire

// ==== testbench/test_utg_top.sv ====
// Purpose: Self-checking bench of the transmit gate and multidrop block.
// Assumes: AHB-Lite single word transfers; hready is looped from hreadyout.
// Notes:   Load counts come from watching tx_load, not from the block's registers.
`timescale 1ns/1ps
`default_nettype none
`include "utg_regs.svh"
module test_utg_top;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, push = 0;
	logic rx_byte_valid = 0, rx_parity = 0, modem_rts = 0, modem_dtr = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] rx_byte = 8'h00;
	logic [8:0] rx_store_data;
	logic hreadyout, hresp, tx_fifo_write, tx_fifo_valid, tx_shift_idle, tx_load, rx_store, rts_out, dtr_out, irq;
	int n_fail = 0, n_compared = 0, cyc = 0, loads = 0;

	utg_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
		.hreadyout, .hrdata, .hresp, .tx_fifo_valid, .tx_fifo_write, .tx_shift_idle, .tx_load, .rx_byte_valid,
		.rx_byte, .rx_parity, .rx_store, .rx_store_data, .modem_rts, .modem_dtr, .rts_out, .dtr_out, .irq);
	utg_tx_model u_line (.hclk, .hresetn, .push, .tx_load, .tx_fifo_write, .tx_fifo_valid, .tx_shift_idle);

	initial forever #25 hclk = ~hclk;
	// Count loads and cut a hang short well beyond the expected run.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (tx_load === 1'b1) loads <= loads + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// One transfer; each phase is held until hready is seen high.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic send(input int n);
		repeat (n) begin
			@(posedge hclk);
			push <= 1'b1;
			@(posedge hclk);
			push <= 1'b0;
		end
	endtask
	task automatic drain;
		do @(posedge hclk); while (tx_fifo_valid || !tx_shift_idle || tx_load);
		tick(3);
	endtask
	task automatic rxb(input logic p, input logic [7:0] b, input logic st);
		@(posedge hclk);
		rx_byte_valid <= 1'b1;
		rx_parity <= p;
		rx_byte <= b;
		@(posedge hclk);
		rx_byte_valid <= 1'b0;
		@(posedge hclk);
		chk(32'(rx_store), 32'(st));
		if (st) chk(32'(rx_store_data), 32'({p, b}));
	endtask

	task automatic t_regs;
		rdchk(`UTG_TX_GATE_ADDR, 32'h0000_0080);
		rdchk(`UTG_MD_CTRL_ADDR, 32'h0);
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'hFFFF_FFFF);
		rdchk(`UTG_MD_CTRL_ADDR, 32'h0000_003F);
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h0);
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'hFFFF_FF7F);
		rdchk(`UTG_TX_GATE_ADDR, 32'h0);
		bus(1'b1, 32'h4000_8040, 32'hFFFF_FFFF);
		rdchk(32'h4000_8040, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_gate;
		int l0;
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'h80);
		l0 = loads;
		send(3);
		drain;
		chk(32'(loads - l0), 32'h3);
		// Clearing the gate holds new loads back and setting it releases them; a load already made still goes out.
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'h0);
		l0 = loads;
		send(2);
		tick(40);
		chk(32'(loads - l0), 32'h0);
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'h80);
		drain;
		chk(32'(loads - l0), 32'h2);
		l0 = loads;
		send(2);
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'h0);
		tick(40);
		chk(32'(loads - l0), 32'h1);
		bus(1'b1, `UTG_TX_GATE_ADDR, 32'h80);
		drain;
		chk(32'(loads - l0), 32'h2);
		$display("t_gate done");
	endtask
	task automatic t_dir;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h10 | 32'(k[0]) << 3 | 32'(k[1]) << 5);
			send(1);
			tick(3);
			chk(32'({rts_out, dtr_out}), 32'(k[0] ? {1'b0, k[1]} : {k[1], 1'b0}));
			drain;
			chk(32'({rts_out, dtr_out}), 32'(k[0] ? {1'b0, !k[1]} : {!k[1], 1'b0}));
		end
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h28);
		modem_rts <= 1'b1;
		tick(3);
		chk(32'({rts_out, dtr_out}), 32'h2);
		chk(32'(irq), 32'h0);
		bus(1'b1, `UTG_IRQ_MASK_ADDR, 32'h2);
		tick(2);
		chk(32'(irq), 32'h1);
		rdchk(`UTG_IRQ_STATUS_ADDR, 32'h2);
		bus(1'b1, `UTG_IRQ_STATUS_ADDR, 32'h2);
		tick(2);
		chk(32'(irq), 32'h0);
		$display("t_dir done");
	endtask
	task automatic t_rx;
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h3);
		rxb(1'b0, 8'h11, 1'b0);
		rxb(1'b1, 8'h22, 1'b1);
		rdchk(`UTG_IRQ_STATUS_ADDR, 32'h5);
		bus(1'b1, `UTG_IRQ_STATUS_ADDR, 32'h7);
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h0);
		rxb(1'b0, 8'h33, 1'b1);
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h2);
		rxb(1'b0, 8'h44, 1'b0);
		bus(1'b1, `UTG_ADDR_MATCH_ADDR, 32'h5A);
		bus(1'b1, `UTG_MD_CTRL_ADDR, 32'h7);
		rxb(1'b1, 8'h33, 1'b0);
		rxb(1'b0, 8'h01, 1'b0);
		rxb(1'b1, 8'h5A, 1'b1);
		rdchk(`UTG_MD_CTRL_ADDR, 32'h5);
		rxb(1'b0, 8'h02, 1'b1);
		rxb(1'b1, 8'h34, 1'b0);
		rdchk(`UTG_MD_CTRL_ADDR, 32'h7);
		$display("t_rx done");
	endtask

	// Reset for two cycles, then run every scenario in turn.
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_gate;
		t_dir;
		t_rx;
		stop_test;
	end
endmodule // test_utg_top
`default_nettype wire

// ==== testbench/utg_top_assertions.sv ====
// Purpose: Port-level checks of the transmit gate and multidrop block.
// Assumes: Bound into utg_top; one clock domain.
// Notes:   Gate and control state are internal, so checks tie outputs to input causes.
`timescale 1ns/1ps
`default_nettype none
module utg_top_chk (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       tx_fifo_valid,
	input wire logic       tx_shift_idle,
	input wire logic       tx_load,
	input wire logic       rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic       rx_parity,
	input wire logic       rx_store,
	input wire logic [8:0] rx_store_data
);
	// Every check shares the bus clock and is silenced in reset.
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// A load is one cycle and only follows a waiting character and an idle shifter.
	property p_load_once; tx_load |=> !tx_load; endproperty
	a_load_once: assert property (p_load_once) else $error("load held too long");
	property p_load_cause; tx_load |-> $past(tx_fifo_valid && tx_shift_idle); endproperty
	a_load_cause: assert property (p_load_cause) else $error("load without cause");

	// Stored bytes come from the byte received one cycle before, parity bit on top.
	property p_store_cause; rx_store |-> $past(rx_byte_valid); endproperty
	a_store_cause: assert property (p_store_cause) else $error("store without byte");
	property p_store_data; rx_store |-> rx_store_data == $past({rx_parity, rx_byte}); endproperty
	a_store_data: assert property (p_store_data) else $error("stored byte differs");

	// Reads take exactly one wait state, writes none, and the response is OKAY.
	property p_read_wait; hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
	property p_write_nowait; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	property p_wait_one; !hreadyout |=> hreadyout; endproperty
	a_wait_one: assert property (p_wait_one) else $error("stall too long");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
endmodule // utg_top_chk
bind utg_top utg_top_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.tx_fifo_valid, .tx_shift_idle, .tx_load, .rx_byte_valid, .rx_byte, .rx_parity, .rx_store, .rx_store_data);
`default_nettype wire

// ==== testbench/utg_tx_model.sv ====
// Purpose: Transmit FIFO and shift register standing beside the gate block.
// Assumes: One push per character; CHAR_CYC is the time a character occupies the shifter.
// Notes:   The shifter drops idle on the edge after a load, as the block expects.
`timescale 1ns/1ps
`default_nettype none
module utg_tx_model #(
	parameter int CHAR_CYC = 12
)(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic push,
	input  wire logic tx_load,
	output logic      tx_fifo_write,
	output logic      tx_fifo_valid,
	output logic      tx_shift_idle
);
	logic [3:0] cnt_q;
	logic [4:0] busy_q;
	assign tx_fifo_write = push;
	assign tx_fifo_valid = (cnt_q != 4'h0);
	assign tx_shift_idle = (busy_q == 5'h00);
	// A character in the shifter always runs to its end, whatever the gate does.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
			busy_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 4'(push) - 4'(tx_load);
			busy_q <= tx_load ? 5'(CHAR_CYC) : (tx_shift_idle ? busy_q : busy_q - 5'h01);
		end
	end
endmodule // utg_tx_model
`default_nettype wire
